// File: hw/fme_pkg.sv
// Package for the flash mode entry and memory sizing block.
// Holds register offsets, reset values, field positions, pulse counts and timing.
// Assumes clk_sys at 250 MHz and an 8-bit register port.
package fme_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] MSS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] ERS_OFS = 8'h01;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h02;
  localparam logic [ADDR_W-1:0] PCNT_OFS = 8'h03;

  // Reset values of the sizing registers; memory size has one per product variant, expansion RAM one shared value
  localparam logic [DATA_W-1:0] MSS_RST_A = 8'hCF;
  localparam logic [DATA_W-1:0] MSS_RST_B = 8'hCC;
  localparam logic [DATA_W-1:0] MSS_RST_F = 8'h08;
  localparam logic [DATA_W-1:0] ERS_RST = 8'h0C;

  // Status register field positions
  localparam int ST_PROG_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_TR_LSB = 2;
  localparam int ST_WAIT_BIT = 4;
  localparam int ST_HOLD_BIT = 5;
  localparam int ST_STBY_BIT = 6;

  // Programming pin pulse counts that pick a transport
  localparam int PCNT_W = 5;
  localparam logic [PCNT_W-1:0] PULSES_3WIRE = 5'h00;
  localparam logic [PCNT_W-1:0] PULSES_UART = 5'h08;
  localparam logic [PCNT_W-1:0] PULSES_PSEUDO = 5'h0C;

  // Oscillation stabilisation wait: 2^17 main clock periods
  localparam int OSC_WAIT_EXP = 17;
  localparam int OSC_WAIT_CYCLES = 1 << OSC_WAIT_EXP;

  // Product variants that differ in the memory size reset value
  typedef enum logic [1:0] {
    VAR_A = 2'b00,
    VAR_B = 2'b01,
    VAR_F = 2'b10
  } fme_variant_type;

  // Serial transport chosen for programming
  typedef enum logic [1:0] {
    TR_NONE = 2'b00,
    TR_3WIRE = 2'b01,
    TR_UART = 2'b10,
    TR_PSEUDO = 2'b11
  } fme_transport_type;

  // Reset sequencer states
  typedef enum logic [2:0] {
    SQ_RESET = 3'b000,
    SQ_OSC_WAIT = 3'b001,
    SQ_RUN = 3'b010,
    SQ_PROG = 3'b011,
    SQ_PROG_HOLD = 3'b100
  } fme_state_type;

endpackage

// File: hw/fme_pulse_if.sv
// Interface between the sequencer and the programming pin pulse counter.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface fme_pulse_if;
  import fme_pkg::*;
  logic clear;
  logic enable;
  logic [PCNT_W-1:0] count;

  // Counter end
  modport cnt (
    input clear,
    input enable,
    output count
  );

  // Sequencer end
  modport ctl (
    output clear,
    output enable,
    input count
  );
endinterface
`default_nettype wire

// File: hw/fme_pulse_count.sv
// Counter of rising edges on the programming voltage pin.
// Assumes the pin is asynchronous to clk_sys; it is synchronised here first.
`timescale 1ns/1ps
`default_nettype none
module fme_pulse_count (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pulse_pin,
  fme_pulse_if.cnt pif
);
  import fme_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic [PCNT_W-1:0] count_q;
  logic rise;

  // Two-stage synchroniser; only sync_q is looked at
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pulse_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;

  // Saturating count, so a runaway pulse train cannot wrap onto a legal value
  always_ff @(posedge clk_sys) begin
    if (!nrst || pif.clear) begin
      count_q <= '0;
    end else if (pif.enable && rise && count_q != {PCNT_W{1'b1}}) begin
      count_q <= count_q + PCNT_W'(1);
    end
  end

  assign pif.count = count_q;
endmodule
`default_nettype wire

// File: hw/fme_top.sv
// Flash mode entry and internal memory sizing block.
// Assumes an 8-bit register port on clk_sys and raw device pins for reset,
// programming voltage level and programming pulses, all asynchronous.
// The core is expected to hold off fetching while cpu_run is low; the
// program counter itself lives outside and is not reset here.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fme_top #(
  parameter fme_pkg::fme_variant_type VARIANT = fme_pkg::VAR_A,
  parameter int OSC_WAIT_CYCLES = fme_pkg::OSC_WAIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic vpp_high,
  input wire logic vpp_pulse,
  input wire logic standby,
  input wire logic [fme_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fme_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fme_pkg::DATA_W-1:0] reg_rdata,
  output logic [fme_pkg::DATA_W-1:0] memory_size_select,
  output logic [fme_pkg::DATA_W-1:0] expansion_ram_size_select,
  output logic cpu_run,
  output logic exec_start,
  output logic pins_hiz,
  output logic prog_mode,
  output fme_pkg::fme_transport_type transport
);
  import fme_pkg::*;

  localparam int OSC_W = $clog2(OSC_WAIT_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_WAIT_CYCLES - 1);

  // Memory size reset value picked by the built variant
  localparam logic [DATA_W-1:0] MSS_RST =
    (VARIANT == VAR_B) ? MSS_RST_B : (VARIANT == VAR_F) ? MSS_RST_F : MSS_RST_A;

  fme_pulse_if pif ();

  logic rst_meta_q;
  logic rst_sync_q;
  logic vpp_meta_q;
  logic vpp_sync_q;
  logic armed_q;
  fme_state_type state_q;
  fme_state_type state_d;
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_done;
  logic in_reset;
  logic sw_write_ok;
  logic [DATA_W-1:0] mss_q;
  logic [DATA_W-1:0] ers_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] status;
  logic cpu_run_q;
  logic exec_start_q;
  logic pins_hiz_q;
  logic prog_mode_q;
  fme_transport_type transport_q;
  fme_transport_type transport_d;

  // Device reset pin comes from outside the clock domain; the synchroniser
  // resets low so that the block stays in reset until the pin is seen high
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= reset_pin_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Programming voltage level, also asynchronous; only the second stage is read
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      vpp_meta_q <= 1'b0;
      vpp_sync_q <= 1'b0;
    end else begin
      vpp_meta_q <= vpp_high;
      vpp_sync_q <= vpp_meta_q;
    end
  end

  // Either the system reset or the device reset pin holds the block in reset
  assign in_reset = !nrst || !rst_sync_q;

  // Programming entry is latched only while the reset pin is held. The last
  // sample before release wins, so a supply that droops as reset lifts still
  // counts; the voltage is not looked at again until the next reset.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if (!rst_sync_q) begin
      armed_q <= vpp_sync_q;
    end
  end

  // Stabilisation counter runs from reset release until the wait expires.
  // It stops at its last value; osc_done then stays high until the next reset.
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      osc_cnt_q <= '0;
    end else if (state_q == SQ_OSC_WAIT && !osc_done) begin
      osc_cnt_q <= osc_cnt_q + OSC_W'(1);
    end
  end

  assign osc_done = (osc_cnt_q == OSC_LAST);

  // Map the counted pulses to a transport; anything else picks none.
  // Counts are compared whole, so a pulse lost to noise lands in the hold state.
  always_comb begin
    unique case (pif.count)
      PULSES_3WIRE: transport_d = TR_3WIRE;
      PULSES_UART: transport_d = TR_UART;
      PULSES_PSEUDO: transport_d = TR_PSEUDO;
      default: transport_d = TR_NONE;
    endcase
  end

  // Pulses are counted only in the window between reset release and the end of the wait.
  // The counter is cleared while reset is held so a stale count never leaks.
  assign pif.clear = in_reset;
  assign pif.enable = (state_q == SQ_OSC_WAIT) && armed_q;

  fme_pulse_count u_pulse (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pulse_pin(vpp_pulse),
    .pif(pif)
  );

  // Reset sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SQ_RESET: begin
        state_d = SQ_OSC_WAIT;
      end
      SQ_OSC_WAIT: begin
        if (osc_done) begin
          if (!armed_q) begin
            state_d = SQ_RUN;
          end else if (transport_d == TR_NONE) begin
            state_d = SQ_PROG_HOLD;
          end else begin
            state_d = SQ_PROG;
          end
        end
      end
      SQ_RUN: begin
        state_d = SQ_RUN;
      end
      SQ_PROG: begin
        state_d = SQ_PROG;
      end
      SQ_PROG_HOLD: begin
        state_d = SQ_PROG_HOLD;
      end
      default: begin
        state_d = SQ_RESET;
      end
    endcase
  end

  // Reset sequencer state; only a new reset leaves the final states
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      state_q <= SQ_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Run flag for the core; execution begins only after the full wait.
  // Decoded from the next state so it rises on the same edge as exec_start.
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      cpu_run_q <= 1'b0;
    end else begin
      cpu_run_q <= (state_d == SQ_RUN) || (state_d == SQ_PROG);
    end
  end

  // One-cycle start pulse when the wait ends, whatever the outcome
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      exec_start_q <= 1'b0;
    end else begin
      exec_start_q <= (state_q == SQ_OSC_WAIT) && (state_d != SQ_OSC_WAIT);
    end
  end

  // Pins float through reset and the stabilisation wait
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      pins_hiz_q <= 1'b1;
    end else begin
      pins_hiz_q <= (state_d == SQ_RESET) || (state_d == SQ_OSC_WAIT);
    end
  end

  // Programming mode flag; it stands until the next reset
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      prog_mode_q <= 1'b0;
    end else if (state_q == SQ_OSC_WAIT && osc_done && armed_q) begin
      prog_mode_q <= 1'b1;
    end
  end

  // Transport choice, taken once at the end of the wait; later pulses are
  // ignored so a chattering pin cannot switch links mid-session
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      transport_q <= TR_NONE;
    end else if (state_q == SQ_OSC_WAIT && osc_done && armed_q) begin
      transport_q <= transport_d;
    end
  end

  // Software may write only once the core runs and not in standby; during
  // reset and the wait both size select registers keep their reset values, and standby
  // freezes whatever is held.
  assign sw_write_ok = cpu_run_q && !standby;

  // Memory size select: whole-byte writes, variant reset value.
  // No check on the value; illegal settings are software's problem.
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      mss_q <= MSS_RST;
    end else if (reg_wr && sw_write_ok && reg_addr == MSS_OFS) begin
      mss_q <= reg_wdata;
    end
  end

  // Expansion RAM size select: whole-byte writes, fixed reset value
  always_ff @(posedge clk_sys) begin
    if (in_reset) begin
      ers_q <= ERS_RST;
    end else if (reg_wr && sw_write_ok && reg_addr == ERS_OFS) begin
      ers_q <= reg_wdata;
    end
  end

  // Read-only status word built from the sequencer outputs and the standby input
  always_comb begin
    status = '0;
    status[ST_PROG_BIT] = prog_mode_q;
    status[ST_RUN_BIT] = cpu_run_q;
    status[ST_TR_LSB +: 2] = transport_q;
    status[ST_WAIT_BIT] = pins_hiz_q;
    status[ST_HOLD_BIT] = (state_q == SQ_PROG_HOLD);
    status[ST_STBY_BIT] = standby;
  end

  // Read data stand for the one cycle after the strobe, zero otherwise.
  // Reads stay open during reset hold so a debugger can see the state.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        MSS_OFS: rdata_q <= mss_q;
        ERS_OFS: rdata_q <= ers_q;
        STAT_OFS: rdata_q <= status;
        PCNT_OFS: rdata_q <= DATA_W'(pif.count);
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign memory_size_select = mss_q;
  assign expansion_ram_size_select = ers_q;
  assign cpu_run = cpu_run_q;
  assign exec_start = exec_start_q;
  assign pins_hiz = pins_hiz_q;
  assign prog_mode = prog_mode_q;
  assign transport = transport_q;

endmodule
`default_nettype wire

// File: sim/fme_checker.sv
// Assertion checker for the flash mode entry and memory sizing block.
// Assumes it is bound to fme_top and sees only its ports on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module fme_checker import fme_pkg::*; #(
  parameter fme_variant_type VARIANT = VAR_A,
  parameter int OSC_WAIT_CYCLES = fme_pkg::OSC_WAIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic standby,
  input wire logic [fme_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fme_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fme_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [fme_pkg::DATA_W-1:0] memory_size_select,
  input wire logic [fme_pkg::DATA_W-1:0] expansion_ram_size_select,
  input wire logic cpu_run,
  input wire logic exec_start,
  input wire logic pins_hiz,
  input wire logic prog_mode,
  input wire fme_pkg::fme_transport_type transport
);
  localparam logic [7:0] MSS_RST = (VARIANT == VAR_B) ? MSS_RST_B :
    (VARIANT == VAR_F) ? MSS_RST_F : MSS_RST_A;
  logic [17:0] wait_q;

  // Length of the floating-pin phase; a counter keeps the long wait cheap
  always_ff @(posedge clk_sys) begin
    if (!nrst || !pins_hiz || !reset_pin_n) wait_q <= 18'h00000;
    else wait_q <= wait_q + 18'h00001;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_reset_values: assert property ($rose(nrst) |-> memory_size_select == MSS_RST
    && expansion_ram_size_select == ERS_RST) else $error("bad reset values");
  a_pin_reset: assert property ($rose(reset_pin_n) |-> memory_size_select == MSS_RST
    && expansion_ram_size_select == ERS_RST) else $error("pin reset values lost");
  a_wait_keeps: assert property (pins_hiz |-> memory_size_select == MSS_RST &&
    expansion_ram_size_select == ERS_RST) else $error("register moved during wait");
  a_mss_write: assert property (reg_wr && reg_addr == MSS_OFS && cpu_run && !standby
    |=> memory_size_select == $past(reg_wdata)) else $error("size write lost");
  a_ers_write: assert property (reg_wr && reg_addr == ERS_OFS && cpu_run && !standby
    |=> expansion_ram_size_select == $past(reg_wdata)) else $error("ram write lost");
  a_mss_read: assert property (reg_rd && reg_addr == MSS_OFS
    |=> reg_rdata == $past(memory_size_select)) else $error("size read wrong");
  a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("stale read");
  a_standby_keep: assert property (standby |=>
    ($stable(memory_size_select) || memory_size_select == MSS_RST) &&
    ($stable(expansion_ram_size_select) || expansion_ram_size_select == ERS_RST))
    else $error("standby changed register");
  a_wait_length: assert property (exec_start |-> wait_q >= OSC_WAIT_CYCLES &&
    wait_q <= OSC_WAIT_CYCLES + 10) else $error("wait length wrong");
  a_exec_pulse: assert property (exec_start |=> !exec_start) else $error("long start");
  a_hiz_release: assert property (exec_start |-> !pins_hiz && $past(pins_hiz))
    else $error("pins released at wrong time");
  a_no_prog_tr: assert property (!prog_mode |-> transport == TR_NONE)
    else $error("transport without programming");
  a_hold_stops: assert property (prog_mode && transport == TR_NONE |-> !cpu_run)
    else $error("core runs in hold");
  a_tr_runs: assert property (prog_mode && transport != TR_NONE |-> cpu_run)
    else $error("core held with transport");
  a_tr_stands: assert property ($changed(transport) |-> exec_start ||
    transport == TR_NONE) else $error("transport changed mid run");

  c_uart: cover property (exec_start && transport == TR_UART);
  c_hold: cover property (exec_start && prog_mode && transport == TR_NONE);
  c_stby_wr: cover property (reg_wr && cpu_run && standby);
endmodule

bind fme_top fme_checker #(.VARIANT(VARIANT), .OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)) fme_checker_i (
  .clk_sys(clk_sys), .nrst(nrst), .reset_pin_n(reset_pin_n), .standby(standby),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .memory_size_select(memory_size_select),
  .expansion_ram_size_select(expansion_ram_size_select), .cpu_run(cpu_run),
  .exec_start(exec_start), .pins_hiz(pins_hiz), .prog_mode(prog_mode),
  .transport(transport)
);
`default_nettype wire

// File: sim/fme_tool.sv
// Model of the on-board programming tool driving reset, voltage and pulses.
// Assumes the device samples these pins asynchronously on its own clock.
`timescale 1ns/1ps
`default_nettype none
module fme_tool (
  input wire logic clk_sys,
  output logic reset_pin_n,
  output logic vpp_high,
  output logic vpp_pulse
);
  // Idle: reset released, no voltage, pulse line low between frames
  initial begin
    reset_pin_n = 1'b1;
    vpp_high = 1'b0;
    vpp_pulse = 1'b0;
  end

  // Hold reset with the chosen voltage, release, then send n pulses
  task automatic session(input logic prog, input int n);
    @(posedge clk_sys);
    #1;
    reset_pin_n = 1'b0;
    vpp_high = prog;
    #200;
    reset_pin_n = 1'b1;
    #40;
    // 48 ns per pulse leaves six device cycles high and low
    repeat (n) begin
      vpp_pulse = 1'b1;
      #24;
      vpp_pulse = 1'b0;
      #24;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench of the flash mode entry block.
// Assumes fme_top, fme_tool and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fme_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic standby = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] mss_out;
  logic [7:0] ers_out;
  logic [7:0] mss_var [1:2];
  logic reset_pin_n, vpp_high, vpp_pulse, cpu_run, exec_start, pins_hiz, prog_mode;
  fme_transport_type transport;
  int fail_count = 0;
  int checked = 0;
  int cnt [4] = '{0, 8, 12, 5};
  fme_transport_type trs [4] = '{TR_3WIRE, TR_UART, TR_PSEUDO, TR_NONE};

  // 250 MHz, well above the UART programming minimum
  always #2 clk_sys = ~clk_sys;

  fme_tool fme_tool_i (.clk_sys(clk_sys), .reset_pin_n(reset_pin_n),
    .vpp_high(vpp_high), .vpp_pulse(vpp_pulse));

  // Short wait so that 12 pulses still fit inside it
  fme_top #(.VARIANT(VAR_A), .OSC_WAIT_CYCLES(256)) fme_top_i (
    .clk_sys(clk_sys), .nrst(nrst), .reset_pin_n(reset_pin_n), .vpp_high(vpp_high),
    .vpp_pulse(vpp_pulse), .standby(standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .memory_size_select(mss_out), .expansion_ram_size_select(ers_out), .cpu_run(cpu_run),
    .exec_start(exec_start), .pins_hiz(pins_hiz), .prog_mode(prog_mode),
    .transport(transport));

  // The other two variants share all inputs; only their reset value is compared here
  for (genvar v = 1; v < 3; v++) begin : g_var
    fme_top #(.VARIANT(fme_variant_type'(v)), .OSC_WAIT_CYCLES(256)) fme_top_i (
      .clk_sys(clk_sys), .nrst(nrst), .reset_pin_n(reset_pin_n), .vpp_high(vpp_high),
      .vpp_pulse(vpp_pulse), .standby(standby), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
      .memory_size_select(mss_var[v]), .expansion_ram_size_select(), .cpu_run(),
      .exec_start(), .pins_hiz(), .prog_mode(), .transport());
  end

  task automatic summarize();
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wait_exec();
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge clk_sys);
      #1;
      if (exec_start === 1'b1) break;
    end
    if (i == 600) begin
      chk(8'h00, 8'h01);
      summarize();
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(MSS_OFS, MSS_RST_A);
    rd(ERS_OFS, ERS_RST);
    chk(mss_out, MSS_RST_A);
    chk(mss_var[1], MSS_RST_B);
    chk(mss_var[2], MSS_RST_F);
    wr(MSS_OFS, 8'h08);
    rd(MSS_OFS, MSS_RST_A);
    wait_exec();
    chk({7'h00, cpu_run}, 8'h01);
    wr(MSS_OFS, MSS_RST_B);
    wr(ERS_OFS, 8'h0A);
    rd(MSS_OFS, MSS_RST_B);
    rd(ERS_OFS, 8'h0A);
    chk(mss_out, MSS_RST_B);
    chk(ers_out, 8'h0A);
    rd(8'h10, 8'h00);
    @(posedge clk_sys);
    standby <= 1'b1;
    wr(ERS_OFS, 8'h0B);
    rd(ERS_OFS, 8'h0A);
    chk(ers_out, 8'h0A);
    @(posedge clk_sys);
    standby <= 1'b0;
    // Pulses without programming voltage must give a normal start
    fme_tool_i.session(1'b0, 8);
    wait_exec();
    rd(STAT_OFS, 8'h02);
    chk(mss_out, MSS_RST_A);
    chk(ers_out, ERS_RST);
    for (int k = 0; k < 4; k++) begin
      fme_tool_i.session(1'b1, cnt[k]);
      rd(MSS_OFS, MSS_RST_A);
      wait_exec();
      rd(STAT_OFS, {2'b00, trs[k] == TR_NONE, 1'b0, trs[k], trs[k] != TR_NONE, 1'b1});
      chk({6'h00, transport}, {6'h00, trs[k]});
    end
    summarize();
  end
endmodule
`default_nettype wire
